// >>> pkg/afs_pkg.sv
// afs_pkg: constants, register map and types of the amplifier fault status block
// assumes a single 20 MHz core clock and a plain strobe register port
package afs_pkg;

  // structure
  localparam int STAGES = 4;          // power output stages watched
  localparam int EVT_W = 2 * STAGES;  // sticky event bits
  localparam int ADDR_W = 8;          // register address width
  localparam int DATA_W = 32;         // register data width
  localparam int CNT_W = 8;           // shutdown pulse counter width

  // timing
  localparam int CLK_PERIOD_NS = 50;  // core clock period
  localparam int SD_PULSE_NS = 1000;  // auto-recovery shutdown pulse length
  localparam int SD_PULSE_CYC = (SD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;    // w: restart latched stages
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;  // sticky events, write one to clear
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h08;    // interrupt mask
  localparam logic [ADDR_W-1:0] REG_LINES = 8'h0c;   // line code and stage state

  // field positions
  localparam int STATUS_SHUT_LSB = 0;       // per stage shutdown entered
  localparam int STATUS_WARN_LSB = STAGES;  // per stage warning rose
  localparam int LINES_CODE_LSB = 0;        // {shutdown, warn} line levels
  localparam int LINES_COND_LSB = 4;        // one-hot decoded condition
  localparam int LINES_SHUT_LSB = 8;        // stages holding shutdown low
  localparam int LINES_AUTO_LSB = 12;       // stages strapped for auto-recovery

  // reset values
  localparam logic [EVT_W-1:0] STATUS_RST = 8'h00;
  localparam logic [EVT_W-1:0] MASK_RST = 8'h00;

  // two-bit line code {shutdown_report_n, overtemp_warn_n}
  localparam logic [1:0] CODE_HOT_ERR = 2'h0;
  localparam logic [1:0] CODE_UV_OR_CUR = 2'h1;
  localparam logic [1:0] CODE_WARN = 2'h2;
  localparam logic [1:0] CODE_NORMAL = 2'h3;

  // one-hot decoded conditions
  localparam logic [3:0] COND_HOT_ERR = 4'h1;
  localparam logic [3:0] COND_UV_OR_CUR = 4'h2;
  localparam logic [3:0] COND_WARN = 4'h4;
  localparam logic [3:0] COND_NORMAL = 4'h8;

  typedef logic [CNT_W-1:0] afs_cnt_t;

  // fault sense of one output stage
  typedef struct packed {
    logic temp_err;   // high temperature error
    logic cur_err;    // high current error
    logic uv_err;     // undervoltage lockout
    logic temp_warn;  // temperature warning level reached
  } afs_stage_flt_t;

  // register port request
  typedef struct packed {
    logic wr;                   // write strobe
    logic rd;                   // read strobe
    logic [ADDR_W-1:0] addr;    // byte address
    logic [DATA_W-1:0] wdata;   // write data
  } afs_bus_req_t;

  typedef enum logic [1:0] {ST_RUN, ST_PULSE, ST_HOLD} afs_stage_st_t;

  // whole state of the block but the reset synchroniser
  typedef struct packed {
    afs_stage_st_t [STAGES-1:0] st;   // per stage recovery state
    afs_cnt_t [STAGES-1:0] cnt;       // per stage pulse counter
    logic [STAGES-1:0] warn_prev;     // warning level last cycle
    logic [EVT_W-1:0] status;         // sticky events
    logic [EVT_W-1:0] mask;           // interrupt enables
    logic [1:0] code;                 // sampled line code
    logic [3:0] cond;                 // decoded condition
    logic [DATA_W-1:0] rdata;         // read answer
    logic sd_oe;                      // pull shutdown line low
    logic otw_oe;                     // pull warning line low
    logic irq;                        // interrupt level
  } afs_state_t;

endpackage

// >>> verilog/afs_fault_status.sv
// afs_fault_status: fault collection, open-drain reporting and decode for amp stages
// assumes synchronous inputs, an external pull-up resolving both open-drain lines,
// and a register master that never issues read and write together
`timescale 1ns/1ns
`default_nettype none

module afs_fault_status #(
  parameter int PULSE_CYCLES = afs_pkg::SD_PULSE_CYC  // auto-recovery pulse, cycles
) (
  input wire logic i_core_clk,                                   // core clock, 20 MHz
  input wire logic i_nrst,                                       // async reset, active low
  input wire afs_pkg::afs_bus_req_t i_bus,                       // register request
  output logic [afs_pkg::DATA_W-1:0] o_rdata,                    // read data, cycle after rd
  output logic o_irq,                                            // interrupt level
  input wire afs_pkg::afs_stage_flt_t [afs_pkg::STAGES-1:0] i_stage_flt,  // stage faults
  input wire logic [afs_pkg::STAGES-1:0] i_stage_mode_strap_a,  // mode strap a per stage
  input wire logic [afs_pkg::STAGES-1:0] i_stage_mode_strap_b,  // mode strap b per stage
  input wire logic [afs_pkg::STAGES-1:0] i_stage_mode_strap_c,  // mode strap c per stage
  input wire logic i_shutdown_report_n_in,                       // shutdown line level
  output logic o_shutdown_report_n_out,                          // shutdown drive value
  output logic o_shutdown_report_n_oe,                           // shutdown drive enable
  input wire logic i_overtemp_warn_n_in,                         // warning line level
  output logic o_overtemp_warn_n_out,                            // warning drive value
  output logic o_overtemp_warn_n_oe                              // warning drive enable
);

  logic [1:0] rst_sync_q;  // reset release synchroniser
  logic rst_n;             // synchronised reset for all other logic
  afs_pkg::afs_state_t s_q;  // registered state
  afs_pkg::afs_state_t s_d;  // next state
  logic [afs_pkg::STAGES-1:0] stage_err;   // any stopping fault
  logic [afs_pkg::STAGES-1:0] stage_auto;  // auto-recovery strapped
  logic [afs_pkg::STAGES-1:0] stage_busy;  // holding shutdown now
  logic [afs_pkg::STAGES-1:0] stage_hot;   // warning pull request
  logic [afs_pkg::STAGES-1:0] restart;     // software restart strobe
  logic [afs_pkg::EVT_W-1:0] clr;          // write-one-to-clear mask
  logic [afs_pkg::EVT_W-1:0] evt;          // events this cycle

  // release reset through two flops, assertion stays asynchronous
  // a raw release near an edge could free some flops a cycle before others
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // per stage decode of faults and straps
  for (genvar g = 0; g < afs_pkg::STAGES; g++) begin : g_stage
    assign stage_err[g] = i_stage_flt[g].temp_err | i_stage_flt[g].cur_err |
                          i_stage_flt[g].uv_err;
    // only the all-low strap pattern recovers by itself
    assign stage_auto[g] = ~i_stage_mode_strap_a[g] & ~i_stage_mode_strap_b[g] &
                           ~i_stage_mode_strap_c[g];
    // any state but run means the stage is sinking the shutdown line
    assign stage_busy[g] = (s_q.st[g] != afs_pkg::ST_RUN);
    // temperature error pulls both lines so the code reads all-low
    assign stage_hot[g] = i_stage_flt[g].temp_warn | i_stage_flt[g].temp_err;
  end

  // next state: register writes, stage machines, line drive, decode, reads
  always_comb begin
    s_d = s_q;
    // strobes of this cycle, idle unless a write or a stage event says otherwise
    restart = '0;
    clr = '0;
    evt = '0;
    // register writes
    // only the low bits of each word carry anything, the rest is ignored
    if (i_bus.wr) begin
      case (i_bus.addr)
        afs_pkg::REG_CTRL: begin
          restart = i_bus.wdata[afs_pkg::STAGES-1:0];
        end
        afs_pkg::REG_STATUS: begin
          clr = i_bus.wdata[afs_pkg::EVT_W-1:0];
        end
        afs_pkg::REG_MASK: begin
          s_d.mask = i_bus.wdata[afs_pkg::EVT_W-1:0];
        end
        default: begin
          // unmapped and read-only writes are dropped
        end
      endcase
    end
    // stage recovery machines
    for (int k = 0; k < afs_pkg::STAGES; k++) begin
      // rising level only, so a warning that stays up counts once
      s_d.warn_prev[k] = i_stage_flt[k].temp_warn;
      if (i_stage_flt[k].temp_warn && !s_q.warn_prev[k]) begin
        evt[afs_pkg::STATUS_WARN_LSB + k] = 1'b1;
      end
      // one small machine per stage; stages never wait on each other
      case (s_q.st[k])
        afs_pkg::ST_RUN: begin
          if (stage_err[k]) begin
            // every stopping fault is recorded, whatever the strap pattern
            evt[afs_pkg::STATUS_SHUT_LSB + k] = 1'b1;
            if (stage_auto[k]) begin
              s_d.st[k] = afs_pkg::ST_PULSE;
              s_d.cnt[k] = afs_pkg::afs_cnt_t'(PULSE_CYCLES - 1);
            end else begin
              s_d.st[k] = afs_pkg::ST_HOLD;
            end
          end
        end
        afs_pkg::ST_PULSE: begin
          // short report, then restart on its own; a lasting fault re-pulses
          if (s_q.cnt[k] == '0) begin
            s_d.st[k] = afs_pkg::ST_RUN;
          end else begin
            s_d.cnt[k] = s_q.cnt[k] - 1'b1;
          end
        end
        afs_pkg::ST_HOLD: begin
          // latched stage waits for software, and only once the fault has gone
          if (restart[k] && !stage_err[k]) begin
            s_d.st[k] = afs_pkg::ST_RUN;
          end
        end
        default: begin
          // stray encoding falls back to run rather than locking up
          s_d.st[k] = afs_pkg::ST_RUN;
        end
      endcase
    end
    // sticky events, a new event wins over a clear in the same cycle
    s_d.status = (s_q.status & ~clr) | evt;
    // wired-OR of stages: any one stage pulling drives the shared line low
    s_d.sd_oe = 1'b0;
    s_d.otw_oe = 1'b0;
    for (int k = 0; k < afs_pkg::STAGES; k++) begin
      s_d.sd_oe = s_d.sd_oe | (s_d.st[k] != afs_pkg::ST_RUN);
      s_d.otw_oe = s_d.otw_oe | stage_hot[k];
    end
    // decode of the resolved lines as one two-bit code
    // the lines are taken after the pull-up has resolved them, so any
    // other driver sharing the wire shows up in the code as well
    s_d.code = {i_shutdown_report_n_in, i_overtemp_warn_n_in};
    case (s_d.code)
      afs_pkg::CODE_HOT_ERR: begin
        s_d.cond = afs_pkg::COND_HOT_ERR;
      end
      afs_pkg::CODE_UV_OR_CUR: begin
        s_d.cond = afs_pkg::COND_UV_OR_CUR;
      end
      afs_pkg::CODE_WARN: begin
        s_d.cond = afs_pkg::COND_WARN;
      end
      default: begin
        s_d.cond = afs_pkg::COND_NORMAL;
      end
    endcase
    // from next status and mask, so the level moves in step with them
    s_d.irq = |(s_d.status & s_d.mask);
    // read answer stands for exactly one cycle
    // zero outside the answer cycle lets a bus mux simply or slaves together
    s_d.rdata = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        afs_pkg::REG_STATUS: begin
          s_d.rdata[afs_pkg::EVT_W-1:0] = s_q.status;
        end
        afs_pkg::REG_MASK: begin
          s_d.rdata[afs_pkg::EVT_W-1:0] = s_q.mask;
        end
        afs_pkg::REG_LINES: begin
          s_d.rdata[afs_pkg::LINES_CODE_LSB +: 2] = s_q.code;
          s_d.rdata[afs_pkg::LINES_COND_LSB +: 4] = s_q.cond;
          s_d.rdata[afs_pkg::LINES_SHUT_LSB +: afs_pkg::STAGES] = stage_busy;
          s_d.rdata[afs_pkg::LINES_AUTO_LSB +: afs_pkg::STAGES] = stage_auto;
        end
        default: begin
          // control register and unmapped addresses read as zero
        end
      endcase
    end
  end

  // state register
  // everything but the reset synchroniser lives in this one register
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: {afs_pkg::STAGES{afs_pkg::ST_RUN}}, cnt: '0, warn_prev: '0,
               status: afs_pkg::STATUS_RST, mask: afs_pkg::MASK_RST,
               code: afs_pkg::CODE_NORMAL, cond: afs_pkg::COND_NORMAL,
               rdata: '0, sd_oe: 1'b0, otw_oe: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops; drive value is always low
  // a stage may only sink a shared line, never source it
  assign o_rdata = s_q.rdata;
  assign o_irq = s_q.irq;
  assign o_shutdown_report_n_out = 1'b0;
  assign o_overtemp_warn_n_out = 1'b0;
  assign o_shutdown_report_n_oe = s_q.sd_oe;
  assign o_overtemp_warn_n_oe = s_q.otw_oe;

  // checks on decode and line drive
  // decode checks compare against line levels, not against stage causes
  a_hot_err_decode: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (!i_shutdown_report_n_in && !i_overtemp_warn_n_in) |=>
      s_q.cond == afs_pkg::COND_HOT_ERR)
    else $error("both lines low not decoded as hot error");
  a_uv_cur_decode: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (!i_shutdown_report_n_in && i_overtemp_warn_n_in) |=>
      s_q.cond == afs_pkg::COND_UV_OR_CUR)
    else $error("shutdown-only code not decoded as undervoltage or current");
  a_warn_normal_decode: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    i_shutdown_report_n_in |=>
      s_q.cond == ($past(i_overtemp_warn_n_in) ? afs_pkg::COND_NORMAL
                                               : afs_pkg::COND_WARN))
    else $error("warning or normal code decoded wrongly");
  a_sd_wired_or: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    o_shutdown_report_n_oe == (|stage_busy))
    else $error("shutdown drive does not follow stage shutdowns");
  a_otw_wired_or: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    rst_n |=> o_overtemp_warn_n_oe == $past(|stage_hot))
    else $error("warning drive does not follow stage warnings");
  a_open_drain_low: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !o_shutdown_report_n_out && !o_overtemp_warn_n_out)
    else $error("open-drain pin would drive high");
  a_irq_level: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    o_irq == (|(s_q.status & s_q.mask)))
    else $error("interrupt does not match unmasked status");
  a_read_one_cycle: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    !i_bus.rd |=> o_rdata == '0)
    else $error("read data stands beyond its cycle");
  // an event and a clear in one cycle: the event must survive
  a_event_wins_clear: assert property (@(posedge i_core_clk) disable iff (!rst_n)
    (rst_n && evt != '0) |=> (s_q.status & $past(evt)) == $past(evt))
    else $error("event bit lost to a clear");

  // per stage recovery checks
  // antecedents that start from run and read inputs also ask for rst_n, so the release edge,
  // where the state is still held in reset, starts no attempt
  for (genvar g = 0; g < afs_pkg::STAGES; g++) begin : g_chk
    a_auto_pulse_start: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (rst_n && s_q.st[g] == afs_pkg::ST_RUN && stage_err[g] && stage_auto[g]) |=>
        (s_q.st[g] == afs_pkg::ST_PULSE && o_shutdown_report_n_oe &&
         s_q.cnt[g] == afs_pkg::afs_cnt_t'(PULSE_CYCLES - 1)))
      else $error("auto-recovery stage did not start its pulse");
    a_auto_pulse_end: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (s_q.st[g] == afs_pkg::ST_PULSE && s_q.cnt[g] == '0) |=>
        s_q.st[g] == afs_pkg::ST_RUN)
      else $error("auto-recovery stage did not restart");
    a_strap_latch: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (rst_n && s_q.st[g] == afs_pkg::ST_RUN && stage_err[g] && !stage_auto[g]) |=>
        s_q.st[g] == afs_pkg::ST_HOLD)
      else $error("strapped latch stage did not hold shutdown");
    a_event_sticky: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (rst_n && s_q.st[g] == afs_pkg::ST_RUN && stage_err[g]) |=>
        s_q.status[afs_pkg::STATUS_SHUT_LSB + g])
      else $error("shutdown event not recorded");
    // a latched stage refuses restart while its fault is still there
    a_hold_refused: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (s_q.st[g] == afs_pkg::ST_HOLD && stage_err[g]) |=>
        s_q.st[g] == afs_pkg::ST_HOLD)
      else $error("latched stage left hold with its fault present");
    a_hold_restart: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (s_q.st[g] == afs_pkg::ST_HOLD && restart[g] && !stage_err[g]) |=>
        s_q.st[g] == afs_pkg::ST_RUN)
      else $error("latched stage ignored its restart");
    // the counter never starts above the programmed pulse length
    a_pulse_bounded: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      s_q.st[g] == afs_pkg::ST_PULSE |-> int'(s_q.cnt[g]) < PULSE_CYCLES)
      else $error("pulse counter beyond its length");
    a_warn_event: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (rst_n && i_stage_flt[g].temp_warn && !s_q.warn_prev[g]) |=>
        s_q.status[afs_pkg::STATUS_WARN_LSB + g])
      else $error("warning rise not recorded");
  end

  // main scenarios
  c_auto_pulse: cover property (@(posedge i_core_clk) disable iff (!rst_n)
    s_q.st[0] == afs_pkg::ST_PULSE ##1 s_q.st[0] == afs_pkg::ST_RUN);
  c_latched_restart: cover property (@(posedge i_core_clk) disable iff (!rst_n)
    s_q.st[0] == afs_pkg::ST_HOLD ##1 s_q.st[0] == afs_pkg::ST_RUN);
  c_hot_err_code: cover property (@(posedge i_core_clk) disable iff (!rst_n)
    s_q.cond == afs_pkg::COND_HOT_ERR);
  c_irq_raised: cover property (@(posedge i_core_clk) disable iff (!rst_n)
    $rose(o_irq));
  c_refused_restart: cover property (@(posedge i_core_clk) disable iff (!rst_n)
    s_q.st[1] == afs_pkg::ST_HOLD && restart[1] && stage_err[1]);

endmodule

`default_nettype wire

// >>> verification/afs_host_model.sv
// afs_host_model: host controller that samples the combined fault lines
// assumes both lines are already resolved by the bench with a pull-up
`timescale 1ns/1ns
`default_nettype none

module afs_host_model (
  input wire logic i_clk,       // host clock
  input wire logic i_nrst,      // reset, active low
  input wire logic i_sd_line,   // combined shutdown line
  input wire logic i_otw_line,  // combined warning line
  input wire logic i_clr,       // clear latched shutdown pulse
  output logic [1:0] o_code,    // synchronised {shutdown, warn} code
  output logic o_sd_seen        // shutdown seen since last clear
);
  logic [1:0] sync1_q;  // first synchroniser stage

  // lines are async to the host, so two flops before any decode
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= 2'h3;
      o_code <= 2'h3;
      o_sd_seen <= 1'b0;
    end else begin
      sync1_q <= {i_sd_line, i_otw_line};
      o_code <= sync1_q;
      // latch short recovery pulses, else they slip by unseen
      if (i_clr) begin
        o_sd_seen <= 1'b0;
      end else if (!o_code[1]) begin
        o_sd_seen <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> verification/tb_amp_fault_status_decoder.sv
// tb_amp_fault_status_decoder: self-checking bench for the fault status block
// assumes a pull-up on both open-drain lines, modelled here
`timescale 1ns/1ns
`default_nettype none

module tb_amp_fault_status_decoder;
  localparam int PULSE = 3;  // short pulse keeps the run brief
  logic clk = 1'b0;  // core clock
  logic nrst = 1'b0;  // reset, active low
  afs_pkg::afs_bus_req_t bus = '0;  // register request
  afs_pkg::afs_stage_flt_t [afs_pkg::STAGES-1:0] flt = '0;  // stage faults
  logic [31:0] rdata;  // read answer
  logic irq, sd_out, sd_oe, otw_out, otw_oe, clr = 1'b0;  // dut and host pins
  logic [1:0] hcode;  // host code
  logic hseen;  // host latched pulse
  logic [31:0] rd_v;  // last read value
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  // open drain lines with a pull-up
  wire sd_line = sd_oe ? sd_out : 1'b1;
  wire otw_line = otw_oe ? otw_out : 1'b1;

  always #25 clk = ~clk;

  afs_fault_status #(.PULSE_CYCLES(PULSE)) u_dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata), .o_irq(irq),
    .i_stage_flt(flt), .i_stage_mode_strap_a(4'h2), .i_stage_mode_strap_b(4'h4),
    .i_stage_mode_strap_c(4'h8), .i_shutdown_report_n_in(sd_line),
    .o_shutdown_report_n_out(sd_out), .o_shutdown_report_n_oe(sd_oe),
    .i_overtemp_warn_n_in(otw_line), .o_overtemp_warn_n_out(otw_out),
    .o_overtemp_warn_n_oe(otw_oe));

  afs_host_model u_host (.i_clk(clk), .i_nrst(nrst), .i_sd_line(sd_line),
    .i_otw_line(otw_line), .i_clr(clr), .o_code(hcode), .o_sd_seen(hseen));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) bus.wr <= 1'b0;
  endtask

  // data stand in the cycle after the taking edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk) bus.rd <= 1'b0;
    @(negedge clk) rd_v = rdata;
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  // line code, condition, held stages and host view together
  task automatic check_lines(input logic [1:0] code, input logic [3:0] cond,
                             input logic [3:0] held);
    wait_cyc(4);
    rd(afs_pkg::REG_LINES);
    check(rd_v[1:0], code);
    check(rd_v[7:4], cond);
    check(rd_v[11:8], held);
    check(rd_v[15:12], 4'h1);
    check(hcode, code);
  endtask

  task automatic test_reset();
    rd(afs_pkg::REG_STATUS);
    check(rd_v, 32'h0);
    rd(afs_pkg::REG_MASK);
    check(rd_v, 32'h0);
    rd(8'h40);
    check(rd_v, 32'h0);
    check_lines(afs_pkg::CODE_NORMAL, afs_pkg::COND_NORMAL, 4'h0);
    $display("test reset done");
  endtask

  // latched stage, refused restart, irq mask and clear
  task automatic test_latched();
    @(posedge clk) flt[1].cur_err <= 1'b1;
    check_lines(afs_pkg::CODE_UV_OR_CUR, afs_pkg::COND_UV_OR_CUR, 4'h2);
    check({sd_oe, sd_out, otw_oe}, 3'h4);
    wr(afs_pkg::REG_MASK, 32'h2);
    wait_cyc(1);
    check(irq, 1'b1);
    wr(afs_pkg::REG_MASK, 32'h0);
    wait_cyc(1);
    check(irq, 1'b0);
    wr(afs_pkg::REG_CTRL, 32'h2);
    @(posedge clk) flt[1].cur_err <= 1'b0;
    wait_cyc(3);
    check(sd_oe, 1'b1);
    wr(afs_pkg::REG_CTRL, 32'h2);
    wait_cyc(2);
    check(sd_oe, 1'b0);
    wr(afs_pkg::REG_MASK, 32'h2);
    wait_cyc(1);
    check(irq, 1'b1);
    wr(afs_pkg::REG_STATUS, 32'h2);
    rd(afs_pkg::REG_STATUS);
    check(rd_v, 32'h0);
    check(irq, 1'b0);
    $display("test latched done");
  endtask

  task automatic test_temp();
    @(posedge clk) flt[2].temp_err <= 1'b1;
    check_lines(afs_pkg::CODE_HOT_ERR, afs_pkg::COND_HOT_ERR, 4'h4);
    check(otw_oe, 1'b1);
    check(otw_out, 1'b0);
    @(posedge clk) flt[2].temp_err <= 1'b0;
    wr(afs_pkg::REG_CTRL, 32'h4);
    @(posedge clk) flt[3].temp_warn <= 1'b1;
    check_lines(afs_pkg::CODE_WARN, afs_pkg::COND_WARN, 4'h0);
    rd(afs_pkg::REG_STATUS);
    check(rd_v[7], 1'b1);
    @(posedge clk) flt[3].temp_warn <= 1'b0;
    check_lines(afs_pkg::CODE_NORMAL, afs_pkg::COND_NORMAL, 4'h0);
    wr(afs_pkg::REG_STATUS, 32'hff);
    $display("test temp done");
  endtask

  // auto stage: brief pulse only, host must still catch it
  task automatic test_auto();
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    flt[0].uv_err <= 1'b1;
    @(posedge clk) flt[0].uv_err <= 1'b0;
    n = 0;
    while (!sd_oe && n < 10) begin
      @(negedge clk);
      n++;
    end
    check(hseen, 1'b0);
    n = 0;
    while (sd_oe && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(n, PULSE);
    wait_cyc(3);
    check(hseen, 1'b1);
    rd(afs_pkg::REG_STATUS);
    check(rd_v, 32'h1);
    check_lines(afs_pkg::CODE_NORMAL, afs_pkg::COND_NORMAL, 4'h0);
    $display("test auto done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
    test_latched();
    test_temp();
    test_auto();
    summarize();
  end

  // hang guard, well above the planned run
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire
